// *** rtl/ckg_if.sv ***
// Interface between the control top and the PLL input divider.
`timescale 1ns/1ps
interface ckg_if;
    logic [ckg_pkg::DIV_W-1:0] div;
    logic [ckg_pkg::MUL_W-1:0] mul;
    logic main_lvl;
    logic main_rise;
    logic pll_lvl;
    logic div_out;
    logic pll_out;
    modport top (output div, output mul, output main_lvl, output main_rise, output pll_lvl,
                 input div_out, input pll_out);
    modport div_side (input div, input mul, input main_lvl, input main_rise, input pll_lvl,
                      output div_out, output pll_out);
endinterface

// *** rtl/ckg_pkg.sv ***
// Package of widths, reset values and states for the clock generator control.
package ckg_pkg;
    localparam int OSC_CNT_W = 8;
    localparam int PRESC_W = 3;
    localparam int DIV_W = 8;
    localparam int MUL_W = 11;
    localparam int PLLCNT_W = 6;
    localparam int MAIN_FREQ_COUNT_W = 16;
    localparam int EDGE_W = 5;
    localparam logic [PRESC_W-1:0] PRESC_LAST = 3'h7;
    localparam logic [EDGE_W-1:0] FREQ_EDGES = 5'h10;
    localparam logic [OSC_CNT_W-1:0] OSC_CNT_RST = 8'h00;
    localparam logic [PRESC_W-1:0] PRESC_RST = 3'h0;
    localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [MUL_W-1:0] MUL_RST = 11'h000;
    localparam logic [PLLCNT_W-1:0] PLLCNT_RST = 6'h00;
    localparam logic [MAIN_FREQ_COUNT_W-1:0] MAIN_FREQ_COUNT_RST = 16'h0000;
    localparam logic [MAIN_FREQ_COUNT_W-1:0] MAIN_FREQ_COUNT_ONE = 16'h0001;
    localparam logic [EDGE_W-1:0] EDGE_RST = 5'h00;
    localparam logic [EDGE_W-1:0] EDGE_ONE = 5'h01;
    localparam logic [1:0] SEL_SLOW = 2'h0;
    localparam logic [1:0] SEL_MAIN = 2'h1;
    localparam logic [1:0] SEL_PLL = 2'h2;
    typedef enum logic [1:0] {FREQ_IDLE, FREQ_WAIT, FREQ_COUNT, FREQ_DONE} ckg_freq_state_t;
endpackage

// *** rtl/ckg_pll_div.sv ***
// PLL input divider and PLL output gating.
`timescale 1ns/1ps
module ckg_pll_div (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    ckg_if.div_side bus
);
    import ckg_pkg::*;

    logic [DIV_W-1:0] cnt_r;
    logic div_out_r;
    logic pll_out_r;

    // Counts main clock edges modulo the divider value.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cnt_r <= DIV_RST;
        end else if (clk_en_i && bus.main_rise) begin
            if (bus.div == DIV_RST || cnt_r >= bus.div - DIV_ONE) begin
                cnt_r <= DIV_RST;
            end else begin
                cnt_r <= cnt_r + DIV_ONE;
            end
        end
    end

    // A zero divider holds both outputs low; a zero multiplier stops the PLL.
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            div_out_r <= 1'b0;
            pll_out_r <= 1'b0;
        end else if (clk_en_i) begin
            if (bus.div == DIV_RST) begin
                div_out_r <= 1'b0;
            end else if (bus.div == DIV_ONE) begin
                div_out_r <= bus.main_lvl;
            end else begin
                div_out_r <= (cnt_r < (bus.div >> 1));
            end
            pll_out_r <= bus.pll_lvl && bus.div != DIV_RST && bus.mul != MUL_RST;
        end
    end

    assign bus.div_out = div_out_r;
    assign bus.pll_out = pll_out_r;
endmodule

// *** rtl/ckg_top.sv ***
// Clock generator control: oscillator start-up, frequency meter, PLL lock.
//
// Function
// - Deliver slow, main and PLL clocks.
// - After reset oscillator off, slow clock selected.
// - Clearing enable stops oscillator, clears stable flag.
// - Enable write clears stable, loads eighth-rate counter.
// - Start-up count is eight bits wide.
// - Counter zero sets stable flag.
// - Frequency count starts after next slow rise.
// - Sixteenth slow fall stops count, sets ready.
// - Count of main cycles is readable.
// - Divider 1..255; zero forces outputs low.
// - Reset zeroes divider, PLL input held low.
// - PLL output is source times (mul+1)/div.
// - Multiplier zero disables PLL, nonzero enables if divider nonzero.
// - PLL rewrite changing div or mul clears lock; loads settle count if mul nonzero.
// - Settle counter decrements per slow clock, sets lock.
// - Multiplier accepts 0 to 2047.
`timescale 1ns/1ps
module ckg_top (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic slow_clk_i,
    input wire logic main_osc_clk_i,
    input wire logic pll_clk_i,
    input wire logic osc_ctrl_wr_i,
    input wire logic osc_enable_bit_i,
    input wire logic osc_bypass_bit_i,
    input wire logic [ckg_pkg::OSC_CNT_W-1:0] osc_startup_count_i,
    input wire logic pll_ctrl_wr_i,
    input wire logic [ckg_pkg::DIV_W-1:0] pll_div_i,
    input wire logic [ckg_pkg::MUL_W-1:0] pll_multiplier_i,
    input wire logic [ckg_pkg::PLLCNT_W-1:0] pll_settle_count_i,
    input wire logic clk_sel_wr_i,
    input wire logic [1:0] clk_sel_i,
    output logic osc_enable_o,
    output logic osc_bypass_o,
    output logic osc_stable_flag_o,
    output logic freq_count_ready_o,
    output logic [ckg_pkg::MAIN_FREQ_COUNT_W-1:0] main_freq_count_o,
    output logic pll_enable_o,
    output logic [ckg_pkg::DIV_W-1:0] pll_div_o,
    output logic [ckg_pkg::MUL_W-1:0] pll_multiplier_o,
    output logic pll_lock_o,
    output logic [1:0] clk_sel_o,
    output logic slow_clk_o,
    output logic main_osc_clk_o,
    output logic pll_ref_clk_o,
    output logic pll_out_clk_o,
    output logic sel_clk_o
);
    import ckg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchronisers and edge detection.

    logic [2:0] slow_sync_r;
    logic [2:0] main_sync_r;
    logic [1:0] pll_sync_r;
    logic slow_rise;
    logic slow_fall;
    logic main_rise;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            slow_sync_r <= 3'h0;
            main_sync_r <= 3'h0;
            pll_sync_r <= 2'h0;
        end else if (clk_en_i) begin
            slow_sync_r <= {slow_sync_r[1:0], slow_clk_i};
            main_sync_r <= {main_sync_r[1:0], main_osc_clk_i};
            pll_sync_r <= {pll_sync_r[0], pll_clk_i};
        end
    end

    assign slow_rise = slow_sync_r[1] && !slow_sync_r[2];
    assign slow_fall = !slow_sync_r[1] && slow_sync_r[2];
    assign main_rise = main_sync_r[1] && !main_sync_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Main oscillator control and start-up counter.

    logic osc_en_r;
    logic bypass_r;
    logic stable_r;
    logic osc_run_r;
    logic [OSC_CNT_W-1:0] osc_cnt_r;
    logic [PRESC_W-1:0] presc_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            osc_en_r <= 1'b0;
            bypass_r <= 1'b0;
            stable_r <= 1'b0;
            osc_run_r <= 1'b0;
            osc_cnt_r <= OSC_CNT_RST;
            presc_r <= PRESC_RST;
        end else if (clk_en_i) begin
            if (osc_ctrl_wr_i) begin
                osc_en_r <= osc_enable_bit_i;
                bypass_r <= osc_bypass_bit_i;
                stable_r <= 1'b0;
                osc_run_r <= osc_enable_bit_i;
                osc_cnt_r <= osc_startup_count_i;
                presc_r <= PRESC_RST;
            end else if (osc_run_r && slow_rise) begin
                presc_r <= presc_r + 3'h1;
                if (osc_cnt_r == OSC_CNT_RST) begin
                    stable_r <= 1'b1;
                    osc_run_r <= 1'b0;
                end else if (presc_r == PRESC_LAST) begin
                    osc_cnt_r <= osc_cnt_r - 8'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main clock frequency meter.

    ckg_freq_state_t freq_state_r;
    logic [EDGE_W-1:0] edge_cnt_r;
    logic [MAIN_FREQ_COUNT_W-1:0] main_freq_count_r;
    logic ready_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            freq_state_r <= FREQ_IDLE;
            edge_cnt_r <= EDGE_RST;
            main_freq_count_r <= MAIN_FREQ_COUNT_RST;
            ready_r <= 1'b0;
        end else if (clk_en_i) begin
            case (freq_state_r)
                FREQ_IDLE: begin
                    if (stable_r) begin
                        freq_state_r <= FREQ_WAIT;
                        main_freq_count_r <= MAIN_FREQ_COUNT_RST;
                        edge_cnt_r <= EDGE_RST;
                    end
                end
                FREQ_WAIT: begin
                    if (slow_rise) begin
                        freq_state_r <= FREQ_COUNT;
                    end
                end
                FREQ_COUNT: begin
                    if (main_rise) begin
                        main_freq_count_r <= main_freq_count_r + MAIN_FREQ_COUNT_ONE;
                    end
                    if (slow_fall) begin
                        edge_cnt_r <= edge_cnt_r + EDGE_ONE;
                        if (edge_cnt_r + EDGE_ONE == FREQ_EDGES) begin
                            freq_state_r <= FREQ_DONE;
                            ready_r <= 1'b1;
                        end
                    end
                end
                FREQ_DONE: begin
                    freq_state_r <= FREQ_DONE;
                end
                default: begin
                    freq_state_r <= FREQ_IDLE;
                end
            endcase
            if (!stable_r) begin
                freq_state_r <= FREQ_IDLE;
                ready_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // PLL configuration and lock counter.

    logic [DIV_W-1:0] div_r;
    logic [MUL_W-1:0] mul_r;
    logic [PLLCNT_W-1:0] pll_cnt_r;
    logic pll_run_r;
    logic lock_r;
    logic pll_change;

    assign pll_change = pll_ctrl_wr_i && (pll_div_i != div_r || pll_multiplier_i != mul_r);

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            div_r <= DIV_RST;
            mul_r <= MUL_RST;
            pll_cnt_r <= PLLCNT_RST;
            pll_run_r <= 1'b0;
            lock_r <= 1'b0;
        end else if (clk_en_i) begin
            if (pll_ctrl_wr_i) begin
                div_r <= pll_div_i;
                mul_r <= pll_multiplier_i;
            end
            if (pll_ctrl_wr_i && pll_multiplier_i == MUL_RST) begin
                lock_r <= 1'b0;
                pll_run_r <= 1'b0;
            end else if (pll_change || (pll_ctrl_wr_i && mul_r == MUL_RST)) begin
                lock_r <= 1'b0;
                pll_run_r <= 1'b1;
                pll_cnt_r <= pll_settle_count_i;
            end else if (pll_run_r && slow_rise) begin
                if (pll_cnt_r == PLLCNT_RST) begin
                    lock_r <= 1'b1;
                    pll_run_r <= 1'b0;
                end else begin
                    pll_cnt_r <= pll_cnt_r - 6'h01;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock selection and clock outputs.

    logic [1:0] sel_r;
    logic slow_out_r;
    logic main_out_r;
    logic sel_out_r;
    logic main_ok;
    ckg_if div_bus();

    assign main_ok = stable_r || bypass_r;

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            sel_r <= SEL_SLOW;
        end else if (clk_en_i && clk_sel_wr_i) begin
            sel_r <= clk_sel_i;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            slow_out_r <= 1'b0;
            main_out_r <= 1'b0;
            sel_out_r <= 1'b0;
        end else if (clk_en_i) begin
            slow_out_r <= slow_sync_r[1];
            main_out_r <= main_ok && main_sync_r[1];
            case (sel_r)
                SEL_MAIN: sel_out_r <= main_out_r;
                SEL_PLL: sel_out_r <= div_bus.pll_out;
                default: sel_out_r <= slow_out_r;
            endcase
        end
    end

    assign div_bus.div = div_r;
    assign div_bus.mul = mul_r;
    assign div_bus.main_lvl = main_ok && main_sync_r[1];
    assign div_bus.main_rise = main_ok && main_rise;
    assign div_bus.pll_lvl = pll_sync_r[1];

    // The analog PLL multiplies the divided reference by mul+1.
    ckg_pll_div u_div (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .clk_en_i(clk_en_i),
        .bus(div_bus.div_side)
    );

    assign osc_enable_o = osc_en_r;
    assign osc_bypass_o = bypass_r;
    assign osc_stable_flag_o = stable_r;
    assign freq_count_ready_o = ready_r;
    assign main_freq_count_o = main_freq_count_r;
    assign pll_enable_o = (mul_r != MUL_RST) && (div_r != DIV_RST);
    assign pll_div_o = div_r;
    assign pll_multiplier_o = mul_r;
    assign pll_lock_o = lock_r;
    assign clk_sel_o = sel_r;
    assign slow_clk_o = slow_out_r;
    assign main_osc_clk_o = main_out_r;
    assign pll_ref_clk_o = div_bus.div_out;
    assign pll_out_clk_o = div_bus.pll_out;
    assign sel_clk_o = sel_out_r;
endmodule

// *** sim/ckg_osc_model.sv ***
// Behavioural slow RC clock, crystal oscillator and analog PLL.
`timescale 1ns/1ps
module ckg_osc_model #(
    parameter real SLOW_HALF = 800.0,
    parameter real MAIN_HALF = 104.3,
    parameter real PLL_HALF = 63.7
) (
    input wire logic osc_enable_i,
    input wire logic osc_bypass_i,
    input wire logic pll_enable_i,
    output logic slow_clk_o,
    output logic main_clk_o,
    output logic pll_clk_o
);
    // The slow clock never stops; a stopped oscillator or PLL rests low.
    initial begin
        slow_clk_o = 1'b0;
        forever #(SLOW_HALF) slow_clk_o = ~slow_clk_o;
    end
    initial begin
        main_clk_o = 1'b0;
        forever #(MAIN_HALF) main_clk_o = (osc_enable_i || osc_bypass_i) & ~main_clk_o;
    end
    initial begin
        pll_clk_o = 1'b0;
        forever #(PLL_HALF) pll_clk_o = pll_enable_i & ~pll_clk_o;
    end
endmodule

// *** sim/ckg_top_chk.sv ***
// Port checker of the clock generator control.
`timescale 1ns/1ps
module ckg_top_chk (
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    input wire logic clk_en_i,
    input wire logic slow_clk_i,
    input wire logic osc_ctrl_wr_i,
    input wire logic osc_enable_bit_i,
    input wire logic pll_ctrl_wr_i,
    input wire logic [ckg_pkg::DIV_W-1:0] pll_div_i,
    input wire logic [ckg_pkg::MUL_W-1:0] pll_multiplier_i,
    input wire logic [ckg_pkg::PLLCNT_W-1:0] pll_settle_count_i,
    input wire logic osc_enable_o,
    input wire logic osc_stable_flag_o,
    input wire logic freq_count_ready_o,
    input wire logic [ckg_pkg::MAIN_FREQ_COUNT_W-1:0] main_freq_count_o,
    input wire logic pll_enable_o,
    input wire logic [ckg_pkg::DIV_W-1:0] pll_div_o,
    input wire logic [ckg_pkg::MUL_W-1:0] pll_multiplier_o,
    input wire logic pll_lock_o,
    input wire logic [1:0] clk_sel_o,
    input wire logic pll_ref_clk_o,
    input wire logic pll_out_clk_o
);
    import ckg_pkg::*;
    logic pll_chg;
    logic slow_d_r;
    logic [7:0] rise_cnt_r;
    logic [PLLCNT_W-1:0] settle_r;
    assign pll_chg = clk_en_i && pll_ctrl_wr_i
        && (pll_div_i != pll_div_o || pll_multiplier_i != pll_multiplier_o);
    // Counts raw slow rises since the last PLL rewrite that changes div or mul.
    always_ff @(posedge sys_clk_i) begin
        slow_d_r <= slow_clk_i;
        if (!rst_b_i || pll_chg) begin
            rise_cnt_r <= 8'h00;
            settle_r <= pll_chg ? pll_settle_count_i : PLLCNT_RST;
        end else if (clk_en_i && slow_clk_i && !slow_d_r && rise_cnt_r != 8'hff) begin
            rise_cnt_r <= rise_cnt_r + 8'h01;
        end
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_osc_wr;
        clk_en_i && osc_ctrl_wr_i;
    endsequence
    property p_reset_state;
        disable iff (1'b0) !rst_b_i |=> !osc_enable_o && !osc_stable_flag_o && !pll_lock_o
            && clk_sel_o == SEL_SLOW && pll_div_o == DIV_RST;
    endproperty
    property p_osc_off;
        s_osc_wr ##0 !osc_enable_bit_i |=> !osc_enable_o && !osc_stable_flag_o;
    endproperty
    property p_osc_on;
        s_osc_wr ##0 osc_enable_bit_i |=> osc_enable_o && !osc_stable_flag_o;
    endproperty
    property p_stable_cause;
        $rose(osc_stable_flag_o) |-> osc_enable_o && $past(osc_enable_o);
    endproperty
    property p_ready_cause;
        $rose(freq_count_ready_o) |-> osc_stable_flag_o;
    endproperty
    property p_count_hold;
        freq_count_ready_o && $past(freq_count_ready_o) |-> $stable(main_freq_count_o);
    endproperty
    property p_pll_enable;
        pll_enable_o == (pll_multiplier_o != MUL_RST && pll_div_o != DIV_RST);
    endproperty
    property p_div_zero;
        (pll_div_o == DIV_RST) [*8] |-> !pll_ref_clk_o && !pll_out_clk_o;
    endproperty
    property p_pll_wr;
        pll_chg |=> !pll_lock_o && pll_div_o == $past(pll_div_i)
            && pll_multiplier_o == $past(pll_multiplier_i);
    endproperty
    property p_lock_early;
        $rose(pll_lock_o) |-> rise_cnt_r >= {2'h0, settle_r};
    endproperty
    property p_lock_late;
        pll_enable_o && !pll_lock_o |-> rise_cnt_r <= {2'h0, settle_r} + 8'h03;
    endproperty
    a_reset_state: assert property (p_reset_state)
        else $error("outputs not cleared by reset");
    a_osc_off: assert property (p_osc_off)
        else $error("oscillator or stable flag left on");
    a_osc_on: assert property (p_osc_on)
        else $error("oscillator start did not clear stable flag");
    a_stable_cause: assert property (p_stable_cause)
        else $error("stable flag set without oscillator");
    a_ready_cause: assert property (p_ready_cause)
        else $error("count ready without stable oscillator");
    a_count_hold: assert property (p_count_hold)
        else $error("frequency count moved while ready");
    a_pll_enable: assert property (p_pll_enable)
        else $error("PLL enable disagrees with divider and multiplier");
    a_div_zero: assert property (p_div_zero)
        else $error("clock output with divider zero");
    a_pll_wr: assert property (p_pll_wr)
        else $error("PLL rewrite not taken or lock kept");
    a_lock_early: assert property (p_lock_early)
        else $error("lock before settle count ran out");
    a_lock_late: assert property (p_lock_late)
        else $error("lock late after settle count");
endmodule
bind ckg_top ckg_top_chk i_ckg_top_chk (.sys_clk_i, .rst_b_i, .clk_en_i, .slow_clk_i,
    .osc_ctrl_wr_i, .osc_enable_bit_i, .pll_ctrl_wr_i, .pll_div_i, .pll_multiplier_i,
    .pll_settle_count_i, .osc_enable_o, .osc_stable_flag_o, .freq_count_ready_o,
    .main_freq_count_o, .pll_enable_o, .pll_div_o, .pll_multiplier_o, .pll_lock_o,
    .clk_sel_o, .pll_ref_clk_o, .pll_out_clk_o);

// *** sim/testbench.sv ***
// Self-checking testbench of the clock generator control.
`timescale 1ns/1ps
module testbench;
    import ckg_pkg::*;
    localparam int SLOW_P = 40;
    localparam real MAIN_HALF = 104.3;
    logic sys_clk_i, rst_b_i, clk_en_i, slow_clk_i, main_osc_clk_i, pll_clk_i;
    logic osc_ctrl_wr_i, osc_enable_bit_i, osc_bypass_bit_i, pll_ctrl_wr_i, clk_sel_wr_i;
    logic [7:0] osc_startup_count_i, pll_div_i;
    logic [10:0] pll_multiplier_i;
    logic [5:0] pll_settle_count_i;
    logic [1:0] clk_sel_i, clk_sel_o;
    logic osc_enable_o, osc_bypass_o, osc_stable_flag_o, freq_count_ready_o, pll_enable_o;
    logic pll_lock_o, slow_clk_o, main_osc_clk_o, pll_ref_clk_o, pll_out_clk_o, sel_clk_o;
    logic [15:0] main_freq_count_o;
    logic [7:0] pll_div_o;
    logic [10:0] pll_multiplier_o;
    int errors = 0;
    int checks = 0;
    int seed = 32'h7ace;
    int t, n, e, i;
    logic seen;
    logic [1:0] snap;
    ckg_top i_ckg_top (.sys_clk_i, .rst_b_i, .clk_en_i, .slow_clk_i, .main_osc_clk_i,
        .pll_clk_i, .osc_ctrl_wr_i, .osc_enable_bit_i, .osc_bypass_bit_i, .osc_startup_count_i,
        .pll_ctrl_wr_i, .pll_div_i, .pll_multiplier_i, .pll_settle_count_i, .clk_sel_wr_i,
        .clk_sel_i, .osc_enable_o, .osc_bypass_o, .osc_stable_flag_o, .freq_count_ready_o,
        .main_freq_count_o, .pll_enable_o, .pll_div_o, .pll_multiplier_o, .pll_lock_o,
        .clk_sel_o, .slow_clk_o, .main_osc_clk_o, .pll_ref_clk_o, .pll_out_clk_o, .sel_clk_o);
    ckg_osc_model #(.MAIN_HALF(MAIN_HALF)) i_ckg_osc_model (.osc_enable_i(osc_enable_o),
        .osc_bypass_i(osc_bypass_o), .pll_enable_i(pll_enable_o), .slow_clk_o(slow_clk_i),
        .main_clk_o(main_osc_clk_i), .pll_clk_o(pll_clk_i));
    function automatic int main_rises(input real ns);
        return int'(ns / (2.0 * MAIN_HALF));
    endfunction
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] got);
        checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, got);
        end
    endtask
    task automatic strobe(input int which);
        @(negedge sys_clk_i);
        case (which)
            0: osc_ctrl_wr_i = 1'b1;
            1: pll_ctrl_wr_i = 1'b1;
            default: clk_sel_wr_i = 1'b1;
        endcase
        @(negedge sys_clk_i);
        {osc_ctrl_wr_i, pll_ctrl_wr_i, clk_sel_wr_i} = 3'h0;
        // Flags one cycle after the write, before a zero count can set them again.
        snap = {osc_stable_flag_o, pll_lock_o};
        @(negedge sys_clk_i);
    endtask
    task automatic wait_hi(input int which, input int lim, output int cnt);
        cnt = 0;
        while (cnt <= lim && (which == 0 ? osc_stable_flag_o : which == 1 ?
               freq_count_ready_o : pll_lock_o) !== 1'b1) begin
            @(negedge sys_clk_i);
            cnt++;
        end
    endtask
    task automatic finish_test();
        if (errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #20 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        repeat (60000) @(posedge sys_clk_i);
        errors++;
        finish_test();
    end
    initial begin
        {rst_b_i, osc_ctrl_wr_i, osc_enable_bit_i, osc_bypass_bit_i, pll_ctrl_wr_i} = 5'h0;
        {clk_sel_wr_i, clk_sel_i, osc_startup_count_i, pll_div_i} = 19'h0;
        {pll_multiplier_i, pll_settle_count_i} = 17'h0;
        clk_en_i = 1'b1;
        repeat (8) @(negedge sys_clk_i);
        chk("osc_enable", 16'h0, osc_enable_o);
        chk("clk_sel", SEL_SLOW, clk_sel_o);
        chk("pll_div", DIV_RST, pll_div_o);
        rst_b_i = 1'b1;
        repeat (20) @(negedge sys_clk_i);
        chk("ref_clk", 16'h0, pll_ref_clk_o);
        for (i = 0; i < 2; i++) begin
            n = (i == 0) ? 0 : 1 + $unsigned($random(seed)) % 3;
            {osc_enable_bit_i, osc_startup_count_i} = {1'b1, 8'(n)};
            strobe(0);
            chk("stable_clr", 16'h0, snap[1]);
            wait_hi(0, (8 * n + 10) * SLOW_P, t);
            chk_rng("stable_t", n > 0 ? (8 * n - 8) * SLOW_P : 0, (8 * n + 10) * SLOW_P, t);
            wait_hi(1, 19 * SLOW_P, t);
            chk_rng("ready_t", 15 * SLOW_P, 18 * SLOW_P, t);
            chk_rng("freq", main_rises(24800.0) - 3, main_rises(25600.0) + 3, main_freq_count_o);
        end
        {osc_enable_bit_i, osc_bypass_bit_i} = 2'b01;
        strobe(0);
        chk("stable_off", 16'h0, osc_stable_flag_o);
        chk("bypass", 16'h1, osc_bypass_o);
        clk_en_i = 1'b0;
        osc_bypass_bit_i = 1'b0;
        strobe(0);
        clk_en_i = 1'b1;
        chk("frozen", 16'h1, osc_bypass_o);
        for (i = 0; i < 3; i++) begin
            clk_sel_i = 2'(i);
            strobe(2);
            chk("clk_sel", 16'(i), clk_sel_o);
            n = 0;
            seen = sel_clk_o;
            repeat (400) begin
                @(negedge sys_clk_i);
                n += (sel_clk_o && !seen);
                seen = sel_clk_o;
            end
            e = i == 0 ? 400 / SLOW_P : i == 1 ? main_rises(16000.0) : 0;
            chk_rng("sel_rate", e > 2 ? e - 2 : 0, e + 2, n);
        end
        {pll_div_i, pll_multiplier_i, pll_settle_count_i} = {8'h0, 11'h7ff, 6'h5};
        strobe(1);
        seen = 1'b0;
        repeat (40) @(negedge sys_clk_i) seen = seen | pll_ref_clk_o | pll_out_clk_o;
        chk("div0_out", 16'h0, {pll_enable_o, seen});
        for (i = 0; i < 5; i++) begin
            pll_div_i = i == 0 ? 8'hff : i == 1 ? 8'h01 : 8'(1 + $unsigned($random(seed)) % 255);
            pll_multiplier_i = i == 0 ? 11'h7ff : 11'(1 + $unsigned($random(seed)) % 2047);
            pll_settle_count_i = i == 1 ? 6'h0 : 6'($random(seed));
            if (i == 4) begin
                pll_multiplier_i = 11'h0;
                strobe(1);
                chk("mul0", 16'h0, {pll_enable_o, pll_lock_o});
                pll_multiplier_i = pll_multiplier_o + 11'h1;
            end
            strobe(1);
            chk("relock", 16'h0, snap[0]);
            chk("mul", 16'(pll_multiplier_i), pll_multiplier_o);
            chk("pll_en", 16'h1, pll_enable_o);
            n = pll_settle_count_i;
            wait_hi(2, (n + 4) * SLOW_P, t);
            chk_rng("lock_t", n > 0 ? (n - 1) * SLOW_P : 0, (n + 3) * SLOW_P, t);
            e = main_rises(16000.0) / pll_div_o;
            n = 0;
            seen = pll_ref_clk_o;
            repeat (400) begin
                @(negedge sys_clk_i);
                n += (pll_ref_clk_o && !seen);
                seen = pll_ref_clk_o;
            end
            chk_rng("ref_rate", e > 2 ? e - 2 : 0, e + 2, n);
        end
        finish_test();
    end
endmodule
